// ### rtl/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_PORT_W        18
`define RSC_WDT_W         16
`define RSC_HOLD_W        5
`define RSC_CLK_NS        5
`define RSC_RST_MIN_NS    100
`define RSC_RST_MIN_CYC   ((`RSC_RST_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_RESET_VECTOR  16'h0000
`define RSC_RST_RELOAD    16'hFFFF
`define RSC_WDT_KEY       8'hA5

`define RSC_OFF_CTRL      8'h00
`define RSC_OFF_RELOAD    8'h04
`define RSC_OFF_KICK      8'h08
`define RSC_OFF_COUNT     8'h0C
`define RSC_OFF_CAUSE     8'h10
`define RSC_OFF_MODE      8'h14
`define RSC_OFF_KEEP      8'h18

`define RSC_CTRL_CMP      0
`define RSC_CTRL_WDT_EN   1
`define RSC_CTRL_LOCK     2
`define RSC_CTRL_PULLUP   3
`define RSC_CTRL_CLK_LO   4
`define RSC_MODE_IDLE     0
`define RSC_MODE_STOP     1
`define RSC_MODE_SHUT     2

`endif

// ### rtl/rsc_pkg.sv
`default_nettype none
`include "rsc_cfg.svh"

package rsc_pkg;

   typedef enum logic [2:0]
   {
      ST_RUN   = 3'b000,
      ST_IDLE  = 3'b001,
      ST_STOP  = 3'b010,
      ST_SHUT  = 3'b011,
      ST_RESET = 3'b100
   } rsc_state_e;

   typedef enum logic [1:0]
   {
      CLK_LPOSC = 2'b00,
      CLK_LFO   = 2'b01,
      CLK_EXT   = 2'b10
   } rsc_clk_e;

   typedef struct packed {
      logic por;
      logic supply;
      logic pin;
      logic wdt;
      logic cmp;
   } rsc_cause_s;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rsc_apb_req_s;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } rsc_apb_rsp_s;

   typedef struct packed {
      logic [`RSC_WDT_W-1:0] count;
      logic                  expire;
   } rsc_wdt_s;

endpackage

`default_nettype wire

// ### rtl/rsc_watchdog.sv
`default_nettype none
`include "rsc_cfg.svh"

module rsc_watchdog
(
   input  wire logic                  i_clk_sys,   // System clock
   input  wire logic                  i_sys_rst,   // Power-on reset
   input  wire logic                  i_clr,       // Restart count
   input  wire logic                  i_en,        // Counting allowed
   input  wire logic                  i_tick,      // Low-frequency oscillator tick
   input  wire logic [`RSC_WDT_W-1:0] i_reload,    // Timeout period
   output logic      [`RSC_WDT_W-1:0] o_count,     // Current count
   output logic                       o_expire     // Timeout pulse
);

   localparam rsc_pkg::rsc_wdt_s RST_S = '0;

   rsc_pkg::rsc_wdt_s q;
   rsc_pkg::rsc_wdt_s d;

   always_comb
   begin
      d        = q;
      d.expire = 1'b0;
      if (i_clr)
      begin
         d.count = '0;
      end
      else if (i_en && i_tick)
      begin
         if (q.count == i_reload)
         begin
            d.count  = '0;
            d.expire = 1'b1;
         end
         else
         begin
            d.count = q.count + `RSC_WDT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         q <= RST_S;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_count  = q.count;
   assign o_expire = q.expire;

endmodule

`default_nettype wire

// ### rtl/rsc_reset_ctrl.sv
`default_nettype none
`include "rsc_cfg.svh"

module rsc_reset_ctrl
(
   input  wire logic                   i_clk_sys,       // System clock
   input  wire logic                   i_sys_rst,       // Power-on reset
   input  wire logic                   i_supply_low,    // Supply under threshold
   input  wire logic                   i_rst_pin_in,    // Reset pin level
   input  wire logic                   i_analog_comparator_zero_out,      // Comparator zero output
   input  wire logic                   i_lfo_tick,      // Low-frequency tick
   input  wire logic                   i_irq_pend,      // Enabled interrupt pending
   input  wire logic [`RSC_PORT_W-1:0] i_port_latch,    // Software port latches
   input  wire logic [`RSC_PORT_W-1:0] i_port_od,       // Software open-drain select
   input  wire rsc_pkg::rsc_apb_req_s  i_apb,           // APB request
   output rsc_pkg::rsc_apb_rsp_s       o_apb,           // APB response
   output logic                        o_sys_rst,       // Internal reset
   output logic                        o_core_halt,     // Core halted
   output logic                        o_pc_clear,      // Program counter clear
   output logic [15:0]                 o_pc_vector,     // Fetch start address
   output logic [`RSC_PORT_W-1:0]      o_port_latch,    // Port latches
   output logic [`RSC_PORT_W-1:0]      o_port_od,       // Port open-drain
   output logic                        o_pullup_en,     // Weak pull-ups
   output logic                        o_rst_pin_out,   // Reset pin drive level
   output logic                        o_rst_pin_oe_n,  // Reset pin drive, low drives
   output logic                        o_irq_disable,   // Interrupts off
   output logic                        o_timer_disable, // Timers off
   output rsc_pkg::rsc_clk_e           o_clk_sel,       // System clock source
   output logic                        o_wdt_en,        // Watchdog enable
   output logic                        o_wdt_clk_lfo,   // Watchdog on low-freq clock
   output logic                        o_regulator_off  // Shutdown of regulator
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      rsc_pkg::rsc_state_e    state;
      logic [`RSC_HOLD_W-1:0] hold;
      rsc_pkg::rsc_cause_s    cause;
      rsc_pkg::rsc_clk_e      clk_sel;
      logic                   cmp_rst_en;
      logic                   wdt_en;
      logic                   wdt_lock;
      logic                   pullup_en;
      logic [`RSC_WDT_W-1:0]  wdt_reload;
      logic                   wdt_kick;
      logic [7:0]             keep;
      rsc_pkg::rsc_apb_rsp_s  apb;
      logic                   sys_rst;
      logic                   halt;
      logic                   pc_clear;
      logic [15:0]            pc_vec;
      logic [`RSC_PORT_W-1:0] port_latch;
      logic [`RSC_PORT_W-1:0] port_od;
      logic                   rst_oe_n;
      logic                   irq_dis;
      logic                   tmr_dis;
      logic                   wdt_lfo;
      logic                   reg_off;
   } rsc_top_s;

   localparam logic [`RSC_HOLD_W-1:0] HOLD_CYC = `RSC_HOLD_W'(`RSC_RST_MIN_CYC);

   // Power-on leaves the block in reset with the cause already known.
   localparam rsc_top_s RST_S = '{
      state      : rsc_pkg::ST_RESET,
      hold       : '0,
      cause      : '{por: 1'b1, default: 1'b0},
      clk_sel    : rsc_pkg::CLK_LPOSC,
      cmp_rst_en : 1'b0,
      wdt_en     : 1'b1,
      wdt_lock   : 1'b0,
      pullup_en  : 1'b1,
      wdt_reload : `RSC_RST_RELOAD,
      wdt_kick   : 1'b0,
      keep       : '0,
      apb        : '0,
      sys_rst    : 1'b1,
      halt       : 1'b1,
      pc_clear   : 1'b1,
      pc_vec     : `RSC_RESET_VECTOR,
      port_latch : '1,
      port_od    : '1,
      rst_oe_n   : 1'b0,
      irq_dis    : 1'b1,
      tmr_dis    : 1'b1,
      wdt_lfo    : 1'b1,
      reg_off    : 1'b0
   };

   rsc_top_s q;
   rsc_top_s d;

   logic [`RSC_WDT_W-1:0] wdt_count;
   logic                  wdt_expire;
   logic                  wdt_run;

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode, shared by data and error answer.

   function automatic logic [32:0] rd_word(input logic [7:0] addr, input rsc_top_s s,
                                           input logic [`RSC_WDT_W-1:0] cnt);
      logic [31:0] w;
      logic        hit;
      w   = '0;
      hit = 1'b1;
      case (addr)
         `RSC_OFF_CTRL:
         begin
            w[`RSC_CTRL_CMP]                   = s.cmp_rst_en;
            w[`RSC_CTRL_WDT_EN]                = s.wdt_en;
            w[`RSC_CTRL_LOCK]                  = s.wdt_lock;
            w[`RSC_CTRL_PULLUP]                = s.pullup_en;
            w[`RSC_CTRL_CLK_LO+1:`RSC_CTRL_CLK_LO] = s.clk_sel;
         end
         `RSC_OFF_RELOAD: w[`RSC_WDT_W-1:0] = s.wdt_reload;
         `RSC_OFF_KICK:   w = '0;
         `RSC_OFF_COUNT:  w[`RSC_WDT_W-1:0] = cnt;
         `RSC_OFF_CAUSE:  w[4:0] = s.cause;
         `RSC_OFF_MODE:   w[2:0] = s.state;
         `RSC_OFF_KEEP:   w[7:0] = s.keep;
         default:         hit = 1'b0;
      endcase
      return {hit, w};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   rsc_pkg::rsc_cause_s src;
   logic                req_any;
   logic                access;
   logic                wr_go;
   logic [32:0]         rd;
   logic                in_rst;

   always_comb
   begin
      d          = q;
      d.wdt_kick = 1'b0;
      rd         = rd_word(i_apb.paddr, q, wdt_count);

      // The reset pin reads back low while we drive it ourselves, so our own
      // drive must not count as an external request.
      src        = '0;
      src.supply = i_supply_low;
      src.pin    = ~i_rst_pin_in & q.rst_oe_n;
      src.wdt    = wdt_expire;
      src.cmp    = q.cmp_rst_en & i_analog_comparator_zero_out;
      if (q.state == rsc_pkg::ST_SHUT)
      begin
         src.supply = 1'b0;
         src.wdt    = 1'b0;
         src.cmp    = 1'b0;
      end
      req_any = |src;

      // APB: one wait state, then pready for a single cycle.
      access      = i_apb.psel & i_apb.penable;
      wr_go       = access & q.apb.pready & i_apb.pwrite;
      d.apb.pready = access & ~q.apb.pready;
      if (access && !q.apb.pready)
      begin
         d.apb.pslverr = ~rd[32];
         d.apb.prdata  = i_apb.pwrite ? 32'h0000_0000 : rd[31:0];
      end
      else
      begin
         d.apb.pslverr = 1'b0;
      end

      if (wr_go && q.state != rsc_pkg::ST_RESET)
      begin
         case (i_apb.paddr)
            `RSC_OFF_CTRL:
            begin
               d.pullup_en = i_apb.pwdata[`RSC_CTRL_PULLUP];
               d.clk_sel   = rsc_pkg::rsc_clk_e'(
                  i_apb.pwdata[`RSC_CTRL_CLK_LO+1:`RSC_CTRL_CLK_LO]);
               d.cmp_rst_en = i_apb.pwdata[`RSC_CTRL_CMP];
               // Once locked the watchdog setup is frozen until the next reset.
               if (!q.wdt_lock)
               begin
                  d.wdt_en   = i_apb.pwdata[`RSC_CTRL_WDT_EN];
                  d.wdt_lock = i_apb.pwdata[`RSC_CTRL_LOCK];
               end
            end
            `RSC_OFF_RELOAD:
            begin
               if (!q.wdt_lock)
               begin
                  d.wdt_reload = i_apb.pwdata[`RSC_WDT_W-1:0];
               end
            end
            `RSC_OFF_KICK:
            begin
               d.wdt_kick = (i_apb.pwdata[7:0] == `RSC_WDT_KEY);
            end
            `RSC_OFF_MODE:
            begin
               if (q.state == rsc_pkg::ST_RUN)
               begin
                  if (i_apb.pwdata[`RSC_MODE_SHUT])
                  begin
                     d.state = rsc_pkg::ST_SHUT;
                  end
                  else if (i_apb.pwdata[`RSC_MODE_STOP])
                  begin
                     d.state = rsc_pkg::ST_STOP;
                  end
                  else if (i_apb.pwdata[`RSC_MODE_IDLE])
                  begin
                     d.state = rsc_pkg::ST_IDLE;
                  end
               end
            end
            `RSC_OFF_KEEP:  d.keep = i_apb.pwdata[7:0];
            default:        d.keep = q.keep;
         endcase
      end

      case (q.state)
         rsc_pkg::ST_RESET:
         begin
            // A request during the hold restarts the minimum hold time.
            if (req_any)
            begin
               d.hold = '0;
            end
            else if (q.hold != HOLD_CYC)
            begin
               d.hold = q.hold + `RSC_HOLD_W'(1);
            end
            else
            begin
               d.state = rsc_pkg::ST_RUN;
            end
         end
         rsc_pkg::ST_IDLE:
         begin
            if (i_irq_pend)
            begin
               d.state = rsc_pkg::ST_RUN;
            end
         end
         rsc_pkg::ST_STOP:
         begin
            d.state = rsc_pkg::ST_STOP;
         end
         rsc_pkg::ST_SHUT:
         begin
            d.state = rsc_pkg::ST_SHUT;
         end
         rsc_pkg::ST_RUN:
         begin
            d.hold = '0;
         end
         default:
         begin
            d.state = rsc_pkg::ST_RESET;
         end
      endcase

      // Any qualified request wins over every mode change above.
      if (req_any)
      begin
         d.state = rsc_pkg::ST_RESET;
         if (q.state != rsc_pkg::ST_RESET)
         begin
            d.hold  = '0;
            d.cause = src;
         end
      end

      in_rst = (d.state == rsc_pkg::ST_RESET);
      if (in_rst)
      begin
         // Defaults reload every reset cycle; keep holds except on power-on.
         d.clk_sel    = rsc_pkg::CLK_LPOSC;
         d.cmp_rst_en = 1'b0;
         d.wdt_en     = 1'b1;
         d.wdt_lock   = 1'b0;
         d.pullup_en  = 1'b1;
         d.wdt_reload = `RSC_RST_RELOAD;
      end

      // RAM has no connection here at all, so no reset reaches it.
      d.sys_rst    = in_rst;
      d.halt       = in_rst || d.state != rsc_pkg::ST_RUN;
      d.pc_clear   = in_rst;
      d.pc_vec     = `RSC_RESET_VECTOR;
      d.irq_dis    = in_rst;
      d.tmr_dis    = in_rst;
      d.port_latch = in_rst ? '1 : i_port_latch;
      d.port_od    = in_rst ? '1 : i_port_od;
      d.rst_oe_n   = !(in_rst && (d.cause.por || d.cause.supply));
      d.wdt_lfo    = 1'b1;
      d.reg_off    = (d.state == rsc_pkg::ST_SHUT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and watchdog.

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         q <= RST_S;
      end
      else
      begin
         q <= d;
      end
   end

   // Clocks are gone in stop and shutdown, so the watchdog cannot fire there.
   assign wdt_run = q.wdt_en & (q.state == rsc_pkg::ST_RUN | q.state == rsc_pkg::ST_IDLE);

   rsc_watchdog u_wdt
   (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_clr     (q.sys_rst | q.wdt_kick),
      .i_en      (wdt_run),
      .i_tick    (i_lfo_tick),
      .i_reload  (q.wdt_reload),
      .o_count   (wdt_count),
      .o_expire  (wdt_expire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign o_apb           = q.apb;
   assign o_sys_rst       = q.sys_rst;
   assign o_core_halt     = q.halt;
   assign o_pc_clear      = q.pc_clear;
   assign o_pc_vector     = q.pc_vec;
   assign o_port_latch    = q.port_latch;
   assign o_port_od       = q.port_od;
   assign o_pullup_en     = q.pullup_en;
   assign o_rst_pin_out   = 1'b0;
   assign o_rst_pin_oe_n  = q.rst_oe_n;
   assign o_irq_disable   = q.irq_dis;
   assign o_timer_disable = q.tmr_dis;
   assign o_clk_sel       = q.clk_sel;
   assign o_wdt_en        = q.wdt_en;
   assign o_wdt_clk_lfo   = q.wdt_lfo;
   assign o_regulator_off = q.reg_off;

endmodule

`default_nettype wire

// ### testbench/rsc_reset_ctrl_assertions.sv
`default_nettype none
`include "rsc_cfg.svh"

module rsc_reset_ctrl_assertions
(
   input wire logic                   i_clk_sys,       // System clock
   input wire logic                   i_sys_rst,       // Power-on reset
   input wire logic                   i_supply_low,    // Supply low
   input wire logic                   i_rst_pin_in,    // Reset pin level
   input wire logic                   o_sys_rst,       // Internal reset
   input wire logic                   o_core_halt,     // Core halted
   input wire logic                   o_pc_clear,      // Counter clear
   input wire logic [15:0]            o_pc_vector,     // Start address
   input wire logic [`RSC_PORT_W-1:0] o_port_latch,    // Port latches
   input wire logic [`RSC_PORT_W-1:0] o_port_od,       // Open-drain
   input wire logic                   o_pullup_en,     // Pull-ups
   input wire logic                   o_rst_pin_out,   // Pin level
   input wire logic                   o_rst_pin_oe_n,  // Pin drive
   input wire logic                   o_irq_disable,   // Interrupts off
   input wire logic                   o_timer_disable, // Timers off
   input wire rsc_pkg::rsc_clk_e      o_clk_sel,       // Clock source
   input wire logic                   o_wdt_en,        // Watchdog on
   input wire logic                   o_wdt_clk_lfo,   // Watchdog clock
   input wire logic                   o_regulator_off  // Shutdown
);

   timeunit 1ns;
   timeprecision 100ps;

////////////////////////////////////////
default clocking cb @(posedge i_clk_sys);
endclocking
default disable iff (i_sys_rst);

// Covers the start of each power-on release; AST_MIN below checks the full length.
sequence s_hold;
   o_sys_rst [*8] ##1 o_sys_rst [*8];
endsequence

sequence s_exit;
   !o_pc_clear && !o_irq_disable && !o_timer_disable && o_wdt_en && o_wdt_clk_lfo
      && o_clk_sel == rsc_pkg::CLK_LPOSC;
endsequence

AST_HALT: assert property (o_sys_rst |-> o_core_halt && o_pc_clear)
   else $error("core runs in reset");
AST_PORTS: assert property (o_sys_rst |-> &o_port_latch && &o_port_od)
   else $error("ports not forced in reset");
AST_OFF: assert property (o_sys_rst |-> o_irq_disable && o_timer_disable && o_pullup_en)
   else $error("interrupt, timer or pull-up wrong in reset");
AST_SUPPLY: assert property (i_supply_low && !o_regulator_off |=> o_sys_rst)
   else $error("supply low without reset");
AST_DRIVE: assert property (i_supply_low && !o_sys_rst && !o_regulator_off
   |=> !o_rst_pin_oe_n && o_rst_pin_out == 1'b0)
   else $error("reset pin not driven low");
AST_PIN: assert property (!i_rst_pin_in && o_rst_pin_oe_n |=> o_sys_rst)
   else $error("pin request ignored");
AST_HOLD: assert property ($fell(i_sys_rst) |-> s_hold)
   else $error("reset released early");
AST_EXIT: assert property ($fell(o_sys_rst) |-> s_exit)
   else $error("state after reset exit wrong");
AST_VEC: assert property (o_pc_clear |-> o_pc_vector == 16'h0000)
   else $error("start address not zero");

// The hold restarts on every entry, so no reset of any cause may be shorter.
localparam int HOLD_MIN = `RSC_RST_MIN_CYC + 1;
logic [7:0] rst_len_q;

always_ff @(posedge i_clk_sys)
begin
   if (i_sys_rst || !o_sys_rst)
   begin
      rst_len_q <= 8'h00;
   end
   else if (rst_len_q != 8'hFF)
   begin
      rst_len_q <= rst_len_q + 8'h01;
   end
end

AST_MIN: assert property ($fell(o_sys_rst) |-> rst_len_q >= HOLD_MIN)
   else $error("reset shorter than minimum hold");

endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_assertions u_chk (.i_clk_sys, .i_sys_rst, .i_supply_low,
   .i_rst_pin_in, .o_sys_rst, .o_core_halt, .o_pc_clear, .o_pc_vector, .o_port_latch,
   .o_port_od, .o_pullup_en, .o_rst_pin_out, .o_rst_pin_oe_n, .o_irq_disable,
   .o_timer_disable, .o_clk_sel, .o_wdt_en, .o_wdt_clk_lfo, .o_regulator_off);

`default_nettype wire

// ### testbench/rsc_core_model.sv
`default_nettype none

module rsc_core_model
(
   input  wire logic        i_clk_sys,  // System clock
   input  wire logic        i_halt,     // Core halted
   input  wire logic        i_pc_clear, // Counter clear
   input  wire logic [15:0] i_pc_vec,   // Start address
   input  wire logic        i_irq_dis,  // Interrupts off
   input  wire logic        i_wake,     // Peripheral interrupt
   input  wire logic        i_pin_oe_n, // Device drives pin
   input  wire logic        i_pin_out,  // Device pin level
   input  wire logic        i_ext_n,    // Board pulls pin low
   output logic             o_irq_pend, // Pending interrupt
   output logic             o_pin,      // Pin wire level
   output logic [15:0]      o_fetch     // First fetch address
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] pc_q;
   logic        first_q;

   assign o_irq_pend = i_wake && !i_irq_dis;
   // The pin has a pull-up, so a released pin reads high unless the board pulls it.
   assign o_pin = i_pin_oe_n ? i_ext_n : (i_pin_out & i_ext_n);

   always_ff @(posedge i_clk_sys)
   begin
      if (i_pc_clear)
      begin
         pc_q    <= i_pc_vec;
         first_q <= 1'b1;
      end
      else if (!i_halt)
      begin
         if (first_q)
            o_fetch <= pc_q;
         first_q <= 1'b0;
         pc_q    <= pc_q + 16'h0001;
      end
   end
endmodule

`default_nettype wire

// ### testbench/mcu_reset_state_controller_bench.sv
`default_nettype none
`include "rsc_cfg.svh"

module mcu_reset_state_controller_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic                   clk, rst, sup, ext_n, cmp, tick, wake, irq, pin, err;
   logic                   srst, halt, pcc, pu, pout, poe_n, idis, tdis, wen, wlfo, roff;
   logic [15:0]            vec, fetch;
   logic [`RSC_PORT_W-1:0] pl, pod, opl, opod;
   logic [31:0]            rd;
   rsc_pkg::rsc_apb_req_s  req;
   rsc_pkg::rsc_apb_rsp_s  rsp;
   rsc_pkg::rsc_clk_e      csel;
   int                     error_cnt, total_checks, n;

   rsc_reset_ctrl u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_supply_low(sup),
      .i_rst_pin_in(pin), .i_analog_comparator_zero_out(cmp), .i_lfo_tick(tick), .i_irq_pend(irq),
      .i_port_latch(pl), .i_port_od(pod), .i_apb(req), .o_apb(rsp), .o_sys_rst(srst),
      .o_core_halt(halt), .o_pc_clear(pcc), .o_pc_vector(vec), .o_port_latch(opl),
      .o_port_od(opod), .o_pullup_en(pu), .o_rst_pin_out(pout), .o_rst_pin_oe_n(poe_n),
      .o_irq_disable(idis), .o_timer_disable(tdis), .o_clk_sel(csel), .o_wdt_en(wen),
      .o_wdt_clk_lfo(wlfo), .o_regulator_off(roff));

   rsc_core_model u_core (.i_clk_sys(clk), .i_halt(halt), .i_pc_clear(pcc), .i_pc_vec(vec),
      .i_irq_dis(idis), .i_wake(wake), .i_pin_oe_n(poe_n), .i_pin_out(pout), .i_ext_n(ext_n),
      .o_irq_pend(irq), .o_pin(pin), .o_fetch(fetch));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

////////////////////////////////////////
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Waits stay bounded so a stuck handshake ends the run instead of hanging it.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (rsp.pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         error_cnt++;
         report_and_stop;
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask

   task wait_run;
      int i;
      for (i = 0; i < 80; i++)
      begin
         @(posedge clk);
         if (srst === 1'b0)
            break;
      end
      if (i == 80)
      begin
         error_cnt++;
         report_and_stop;
      end
   endtask

   task pulse(input int k);
      @(posedge clk);
      sup <= (k == 0);
      ext_n <= (k != 1);
      cmp <= (k == 2);
      cyc(2);
      sup <= 1'b0;
      ext_n <= 1'b1;
      cmp <= 1'b0;
   endtask

   task tick1;
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cyc(2);
   endtask

////////////////////////////////////////
   task t_por;
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0010, rd);
      apb(1'b0, `RSC_OFF_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_000A, rd);
      chk("clk", rsc_pkg::CLK_LPOSC, csel);
      chk("wdt", 2'b11, {wen, wlfo});
      chk("fetch", 16'h0000, fetch);
      chk("pull", 1'b1, pu);
   endtask

   task t_cfg;
      apb(1'b1, `RSC_OFF_KEEP, 32'h0000_005A);
      apb(1'b1, `RSC_OFF_CTRL, 32'h0000_0020);
      cyc(1);
      chk("clk", rsc_pkg::CLK_EXT, csel);
      chk("pull", 1'b0, pu);
      chk("latch", pl, opl);
      chk("od", pod, opod);
      pulse(1);
      chk("latch rst", 32'h0003_FFFF, opl);
      chk("drive", 1'b1, poe_n);
      chk("irq", 2'b11, {idis, tdis});
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0004, rd);
      apb(1'b0, `RSC_OFF_KEEP, 32'h0000_0000);
      chk("keep", 32'h0000_005A, rd);
      apb(1'b0, `RSC_OFF_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_000A, rd);
      chk("pull", 1'b1, pu);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("slverr", 1'b1, err);
   endtask

   task t_src;
      pulse(0);
      chk("drive", 1'b0, poe_n);
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0008, rd);
      pulse(2);
      chk("cmp off", 1'b0, srst);
      apb(1'b1, `RSC_OFF_CTRL, 32'h0000_000B);
      pulse(2);
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0001, rd);
      apb(1'b1, `RSC_OFF_RELOAD, 32'h0000_0003);
      apb(1'b1, `RSC_OFF_CTRL, 32'h0000_000F);
      apb(1'b1, `RSC_OFF_RELOAD, 32'h0000_0001);
      tick1;
      tick1;
      apb(1'b1, `RSC_OFF_KICK, 32'h0000_00A5);
      apb(1'b0, `RSC_OFF_COUNT, 32'h0000_0000);
      chk("count", 32'h0000_0000, rd);
      for (n = 1; n < 20 && srst !== 1'b1; n++)
      begin
         tick1;
      end
      chk("ticks", 1'b1, n >= 4 && n <= 6);
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0002, rd);
   endtask

   task t_modes;
      apb(1'b1, `RSC_OFF_MODE, 32'h0000_0001);
      @(posedge clk);
      chk("idle", 1'b1, halt);
      wake <= 1'b1;
      cyc(2);
      chk("idle exit", 1'b0, halt);
      apb(1'b1, `RSC_OFF_MODE, 32'h0000_0002);
      cyc(10);
      chk("stop", 2'b10, {halt, srst});
      wake <= 1'b0;
      pulse(1);
      wait_run;
      chk("stop exit", 1'b0, halt);
      apb(1'b1, `RSC_OFF_CTRL, 32'h0000_000B);
      apb(1'b1, `RSC_OFF_MODE, 32'h0000_0004);
      cyc(2);
      chk("shut", 1'b1, roff);
      pulse(0);
      pulse(2);
      cyc(2);
      chk("shut src", 1'b0, srst);
      pulse(1);
      wait_run;
      chk("shut exit", 2'b00, {roff, halt});
      @(posedge clk);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      wait_run;
      apb(1'b0, `RSC_OFF_CAUSE, 32'h0000_0000);
      chk("cause", 32'h0000_0010, rd);
      apb(1'b0, `RSC_OFF_KEEP, 32'h0000_0000);
      chk("keep", 32'h0000_0000, rd);
   endtask

   initial
   begin
      rst = 1'b1;
      sup = 1'b0;
      ext_n = 1'b1;
      cmp = 1'b0;
      tick = 1'b0;
      wake = 1'b0;
      pl = 18'h1_5555;
      pod = 18'h0_0F0F;
      req = '0;
      error_cnt = 0;
      total_checks = 0;
      cyc(2);
      rst <= 1'b0;
      t_por;
      t_cfg;
      t_src;
      t_modes;
      report_and_stop;
   end
endmodule

`default_nettype wire
